/* dv/quad_encoder_model.sv */
// behavioural rotary encoder with contact bounce on every edge
`timescale 1ns/1ps
module quad_encoder_model #(
    parameter int BOUNCES = 3
) (
    input  wire logic step_go,
    input  wire logic step_cw,
    output logic      phase_a,
    output logic      phase_b
);
    logic [1:0] pos;
    logic       new_a;
    logic       new_b;
    logic       chg_a;
    // detent start, both contacts open
    initial begin
        pos = 2'h0;
        phase_a = 1'b0;
        phase_b = 1'b0;
    end
    // gray walk: a leads b when stepping up, one contact per move
    always @(posedge step_go) begin
        pos = step_cw ? pos + 2'h1 : pos - 2'h1;
        new_a = pos[1] ^ pos[0];
        new_b = pos[1];
        chg_a = new_a != phase_a;
        // moving contact chatters before it settles
        repeat (2 * BOUNCES) begin
            #30;
            if (chg_a) phase_a = ~phase_a;
            else phase_b = ~phase_b;
        end
        phase_a = new_a;
        phase_b = new_b;
    end
endmodule : quad_encoder_model

/* dv/quad_pulser_monitor.sv */
// assertion checker for the quadrature pulser output pins
`timescale 1ns/1ps
module quad_pulser_monitor
    import quad_pulser_pkg::*;
#(
    parameter int POR_CYCLES   = 50,
    parameter int LEAD_CYCLES  = 20,
    parameter int PULSE_CYCLES = 20,
    parameter int TAIL_CYCLES  = 20
) (
    input wire logic                      core_clk,
    input wire logic                      rstn,
    input wire logic                      phase_a,
    input wire logic                      phase_b,
    input wire logic                      clk_invert,
    input wire quad_pulser_pkg::step_out_s step_out,
    input wire quad_pulser_pkg::step_out_s step_oe
);
    import quad_pulser_pkg::*;

    // ==================
    // helpers
    // ==================
    localparam int LEAD_M1  = LEAD_CYCLES - 1;
    localparam int PULSE_M1 = PULSE_CYCLES - 1;
    localparam int TAIL_M1  = TAIL_CYCLES - 1;
    localparam int TOTAL    = LEAD_CYCLES + PULSE_CYCLES + TAIL_CYCLES;
    // wide enough for the full-length power-on and sequence times
    logic [31:0] por_reg;
    logic [31:0] low_reg;
    // polarity removed; only trusted while select is low
    wire logic act = step_out.clk_out ^ clk_invert;

    // cycles since reset, and cycles with select held low
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            por_reg <= 32'h00000000;
            low_reg <= 32'h00000000;
        end else begin
            if (por_reg != 32'hFFFFFFFF) por_reg <= por_reg + 32'h00000001;
            low_reg <= step_out.sel_n ? 32'h00000000
                                      : low_reg + 32'h00000001;
        end
    end

    // ==================
    // sequences
    // ==================
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_lead;
        ((!act && !step_out.sel_n) throughout ##LEAD_M1 1'b1) ##1 act;
    endsequence
    sequence s_pulse;
        ((act && !step_out.sel_n) throughout ##PULSE_M1 1'b1) ##1 !act;
    endsequence
    sequence s_tail;
        ((!act && !step_out.sel_n) throughout ##TAIL_M1 1'b1)
            ##1 step_out.sel_n;
    endsequence

    // ==================
    // assertions
    // ==================
    chk_lead_time: assert property (
        $fell(step_out.sel_n) |-> s_lead)
        else $error("clock pulse not at lead time");
    chk_pulse_width: assert property (
        $rose(act) && !step_out.sel_n |-> s_pulse)
        else $error("clock pulse width wrong");
    chk_tail_time: assert property (
        $fell(act) && !step_out.sel_n |-> s_tail)
        else $error("select release time wrong");
    chk_dir_steady: assert property (
        !step_out.sel_n |-> $stable(step_out.dir_up))
        else $error("direction moved while selected");
    chk_dir_only_step: assert property (
        $changed(step_out.dir_up) |-> ##1 $fell(step_out.sel_n))
        else $error("direction moved outside a step");
    chk_idle_level: assert property (
        ($stable(clk_invert) && step_out.sel_n && step_oe.sel_n) [*5]
        |-> step_out.clk_out == clk_invert)
        else $error("clock idle level wrong");
    chk_por_quiet: assert property (
        por_reg < POR_CYCLES |-> step_oe == 3'h0)
        else $error("pins driven during power-on time");
    chk_oe_whole: assert property (
        step_oe == 3'h0 || step_oe == 3'h7)
        else $error("output enables split");
    chk_seq_length: assert property (
        $rose(step_out.sel_n) |-> low_reg == TOTAL)
        else $error("select low length wrong");
endmodule : quad_pulser_monitor

bind quadrature_updown_pulser quad_pulser_monitor #(
    .POR_CYCLES(POR_CYCLES), .LEAD_CYCLES(LEAD_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES), .TAIL_CYCLES(TAIL_CYCLES)) u_mon (
    .core_clk(core_clk), .rstn(rstn), .phase_a(phase_a),
    .phase_b(phase_b), .clk_invert(clk_invert), .step_out(step_out),
    .step_oe(step_oe));

/* dv/test_quadrature_updown_pulser.sv */
// self-checking bench for the quadrature up/down pulser
`timescale 1ns/1ps
module test_quadrature_updown_pulser;
    import quad_pulser_pkg::*;
    localparam int POR   = 50;
    localparam int LEAD  = 20;
    localparam int PULSE = 20;
    localparam int TAIL  = 20;
    logic      core_clk;
    logic      rstn;
    logic      clk_invert;
    logic      step_go;
    logic      step_cw;
    wire logic phase_a;
    wire logic phase_b;
    step_out_s step_out;
    step_out_s step_oe;
    int        fails = 0;
    int        n_checks = 0;
    int        cycles = 0;

    quadrature_updown_pulser #(.POR_CYCLES(POR), .DEBOUNCE_CYCLES(128),
        .LEAD_CYCLES(LEAD), .PULSE_CYCLES(PULSE), .TAIL_CYCLES(TAIL)) uut (
        .core_clk(core_clk), .rstn(rstn), .phase_a(phase_a),
        .phase_b(phase_b), .clk_invert(clk_invert), .step_out(step_out),
        .step_oe(step_oe));
    quad_encoder_model enc (.step_go(step_go), .step_cw(step_cw),
        .phase_a(phase_a), .phase_b(phase_b));

    // ==================
    // clock, hang guard
    // ==================
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // whole run needs about 4200 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end

    // ==================
    // shared tasks
    // ==================
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic move(input logic cw);
        tick(1);
        step_cw = cw;
        step_go = 1'b1;
        tick(1);
        step_go = 1'b0;
    endtask : move
    // follows one whole select/clock sequence, idle level from polarity
    task automatic expect_step(input logic dir);
        int n;
        n = 0;
        while (step_out.sel_n !== 1'b0 && n < 400) begin
            tick(1);
            n++;
        end
        check("step seen", 1'b1, n < 400);
        check("direction", dir, step_out.dir_up);
        n = 0;
        while (step_out.clk_out === clk_invert && n < 100) begin
            tick(1);
            n++;
        end
        check("lead", LEAD, n);
        n = 0;
        while (step_out.clk_out !== clk_invert && n < 100) begin
            tick(1);
            n++;
        end
        check("pulse", PULSE, n);
        n = 0;
        while (step_out.sel_n === 1'b0 && n < 100) begin
            tick(1);
            n++;
        end
        check("tail", TAIL, n);
    endtask : expect_step
    task automatic expect_none(input int cyc);
        int lows;
        lows = 0;
        repeat (cyc) begin
            tick(1);
            if (step_out.sel_n !== 1'b1) lows++;
        end
        check("no step", 32'h0, lows);
    endtask : expect_none
    task automatic close_out();
        if (fails == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // ==================
    // scenarios
    // ==================
    task automatic t_startup();
        tick(2);
        check("oe in por", 3'h0, step_oe);
        tick(POR + 4);
        check("oe after por", 3'h7, step_oe);
        check("idle pins", 3'h4, step_out);
        move(1'b1);
        expect_none(400);
    endtask : t_startup
    task automatic t_cw_run();
        repeat (4) begin
            move(1'b1);
            expect_step(1'b1);
        end
    endtask : t_cw_run
    // same contact back and forth must never step
    task automatic t_chatter();
        move(1'b0);
        tick(300);
        move(1'b1);
        tick(300);
        move(1'b0);
        expect_none(500);
        check("dir kept", 1'b1, step_out.dir_up);
    endtask : t_chatter
    task automatic t_ccw_run();
        clk_invert = 1'b1;
        tick(6);
        check("inverted idle", 1'b1, step_out.clk_out);
        repeat (4) begin
            move(1'b0);
            expect_step(1'b0);
        end
    endtask : t_ccw_run
    // second edge lands mid-sequence and is dropped
    task automatic t_overlap();
        move(1'b0);
        tick(30);
        move(1'b0);
        expect_step(1'b0);
        expect_none(400);
    endtask : t_overlap

    initial begin
        rstn = 1'b0;
        clk_invert = 1'b0;
        step_go = 1'b0;
        step_cw = 1'b1;
        tick(3);
        rstn = 1'b1;
        t_startup();
        t_cw_run();
        t_chatter();
        t_ccw_run();
        t_overlap();
        close_out();
    end
endmodule : test_quadrature_updown_pulser

/* src/phase_filter.sv */
// averaging filter with hysteresis and stability timer for one phase input
`timescale 1ns/1ps
module phase_filter
    import quad_pulser_pkg::*;
#(
    parameter int STABLE_CYC = DEBOUNCE_CYC
) (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic raw_in,
    input  wire logic init_level,
    input  wire logic init_load,
    output logic      clean_out
);
    import quad_pulser_pkg::*;

    logic [FILT_W-1:0]  acc_reg;
    logic [TIMER_W-1:0] tmr_reg;
    logic               lvl_reg;
    logic               tick_reg;
    logic [7:0]         pre_reg;

    // ======================================================================
    // integrator sampled at most every 256 cycles, so only about 30 us of bounce averages out
    // ======================================================================
    localparam int TICK_DIV = (STABLE_CYC / 64 > 1) ? STABLE_CYC / 64 : 1;
    localparam logic [7:0] TICK_LAST = 8'(TICK_DIV > 255 ? 255 : TICK_DIV - 1);

    wire pre_wrap = (pre_reg == TICK_LAST);
    wire acc_up   = tick_reg && raw_in && (acc_reg != FILT_MAX);
    wire acc_dn   = tick_reg && !raw_in && (acc_reg != '0);
    // comparator output with hysteresis
    wire want_hi  = (acc_reg >= FILT_HI);
    wire want_lo  = (acc_reg <= FILT_LO);
    wire differs  = (want_hi && !lvl_reg) || (want_lo && lvl_reg);
    wire expired  = (tmr_reg >= TIMER_W'(STABLE_CYC));

    // prescaler for integrator steps
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pre_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            pre_reg  <= pre_wrap ? 8'h00 : pre_reg + 8'h01;
            tick_reg <= pre_wrap;
        end
    end

    // integrator
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            acc_reg <= '0;
        end else if (init_load) begin
            acc_reg <= init_level ? FILT_MAX : '0;
        end else if (acc_up) begin
            acc_reg <= acc_reg + 1'b1;
        end else if (acc_dn) begin
            acc_reg <= acc_reg - 1'b1;
        end
    end

    // stability timer: noise that pulls the integrator back past the hysteresis level restarts it, so period grows with noise
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tmr_reg <= '0;
            lvl_reg <= 1'b0;
        end else if (init_load) begin
            tmr_reg <= '0;
            lvl_reg <= init_level;
        end else if (!differs) begin
            tmr_reg <= '0;
        end else if (expired) begin
            tmr_reg <= '0;
            lvl_reg <= ~lvl_reg;
        end else begin
            tmr_reg <= tmr_reg + 1'b1;
        end
    end

    assign clean_out = lvl_reg;

endmodule : phase_filter

/* src/quad_pulser_pkg.sv */
// shared constants and types for the quadrature up/down pulser
package quad_pulser_pkg;

    // ======================================================================
    // clock and timing
    // ======================================================================
    localparam int CLK_MHZ          = 125;
    localparam int STEP_DELAY_US    = 200;   // select low to clock pulse
    localparam int PULSE_WIDTH_US   = 200;   // active clock pulse width
    localparam int TAIL_US          = 200;   // clock end to select release
    localparam int POR_MS           = 30;    // internal power-on quiet time
    localparam int DEBOUNCE_US      = 5500;  // typical qualification time
    localparam int STEP_DELAY_CYC   = STEP_DELAY_US * CLK_MHZ;
    localparam int PULSE_WIDTH_CYC  = PULSE_WIDTH_US * CLK_MHZ;
    localparam int TAIL_CYC         = TAIL_US * CLK_MHZ;
    localparam int POR_CYC          = POR_MS * 1000 * CLK_MHZ;
    localparam int DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;

    // ======================================================================
    // filter shape
    // ======================================================================
    localparam int FILT_W           = 4;     // integrator width
    localparam logic [FILT_W-1:0] FILT_HI  = 4'hC; // upper hysteresis level
    localparam logic [FILT_W-1:0] FILT_LO  = 4'h3; // lower hysteresis level
    localparam logic [FILT_W-1:0] FILT_MAX = 4'hF;
    localparam int TIMER_W          = 32;

    // ======================================================================
    // types
    // ======================================================================
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_LEAD  = 2'b01,
        SEQ_PULSE = 2'b10,
        SEQ_TAIL  = 2'b11
    } seq_state_e;

    typedef struct packed {
        logic sel_n;    // active-low select
        logic clk_out;  // clock pulse, polarity applied
        logic dir_up;   // direction level
    } step_out_s;

endpackage : quad_pulser_pkg

/* src/quadrature_updown_pulser.sv */
// quadrature encoder to select/clock/direction step pulser
`timescale 1ns/1ps
module quadrature_updown_pulser
    import quad_pulser_pkg::*;
#(
    parameter int POR_CYCLES      = POR_CYC,
    parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int LEAD_CYCLES     = STEP_DELAY_CYC,
    parameter int PULSE_CYCLES    = PULSE_WIDTH_CYC,
    parameter int TAIL_CYCLES     = TAIL_CYC
) (
    input  wire logic               core_clk,
    input  wire logic               rstn,
    input  wire logic               phase_a,
    input  wire logic               phase_b,
    input  wire logic               clk_invert,
    output quad_pulser_pkg::step_out_s step_out,
    output quad_pulser_pkg::step_out_s step_oe
);
    import quad_pulser_pkg::*;

    // ======================================================================
    // synchronizers
    // ======================================================================
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    wire  [2:0] pins_raw = {clk_invert, phase_b, phase_a};

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    wire a_sync   = sync2_reg[0];
    wire b_sync   = sync2_reg[1];
    wire inv_sync = sync2_reg[2];

    // ======================================================================
    // internal power-on timer
    // ======================================================================
    logic [TIMER_W-1:0] por_reg;
    logic               ready_reg;
    logic               init_pulse_reg;
    wire por_done = (por_reg >= TIMER_W'(POR_CYCLES - 1));

    // counts from reset release; outputs stay undriven meanwhile
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            por_reg        <= '0;
            ready_reg      <= 1'b0;
            init_pulse_reg <= 1'b0;
        end else begin
            if (!por_done) begin
                por_reg <= por_reg + 1'b1;
            end
            ready_reg      <= por_done;
            init_pulse_reg <= por_done && !ready_reg;
        end
    end

    // ======================================================================
    // debounce filters, one per phase
    // ======================================================================
    wire [1:0] ph_sync = {b_sync, a_sync};
    wire [1:0] ph_clean;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            phase_filter #(
                .STABLE_CYC (DEBOUNCE_CYCLES)
            ) u_filt (
                .core_clk   (core_clk),
                .rstn       (rstn),
                .raw_in     (ph_sync[gi]),
                .init_level (ph_sync[gi]),
                .init_load  (init_pulse_reg),
                .clean_out  (ph_clean[gi])
            );
        end
    endgenerate

    // ======================================================================
    // direction decoding
    // ======================================================================
    logic [1:0] prev_reg;
    logic [1:0] seen_reg;     // which phases have changed since startup
    logic       last_ch_reg;  // phase that moved last (0 = a, 1 = b)
    logic       chatter_reg;  // same phase moved twice in a row

    // follow the filters' preload, or a high pin at power-on would look
    // like a first edge one cycle after the load
    wire [1:0] prev_next = init_pulse_reg ? ph_sync : ph_clean;
    wire a_edge = ready_reg && (ph_clean[0] != prev_reg[0]);
    wire b_edge = ready_reg && (ph_clean[1] != prev_reg[1]);
    wire any_edge = a_edge ^ b_edge;   // both at once is illegal, dropped
    wire this_ch  = b_edge;
    // a moving to differ from b, or b moving to equal a, is clockwise
    wire cw_move = a_edge ? (ph_clean[0] != ph_clean[1])
                          : (ph_clean[0] == ph_clean[1]);
    wire repeat_ch = (seen_reg == 2'b11) && (this_ch == last_ch_reg);
    wire both_seen = (seen_reg | {b_edge, a_edge}) == 2'b11;
    // a step needs alternating phases; a lone phase retoggling only
    // returns to where it was, so it is blocked until the other moves
    wire step_req = any_edge && both_seen
                 && !(repeat_ch && !chatter_reg ? 1'b1 : chatter_reg
                      && this_ch == last_ch_reg);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prev_reg    <= 2'h0;
            seen_reg    <= 2'h0;
            last_ch_reg <= 1'b0;
            chatter_reg <= 1'b0;
        end else if (!ready_reg || init_pulse_reg) begin
            prev_reg    <= prev_next;
        end else begin
            prev_reg <= prev_next;
            if (any_edge) begin
                seen_reg    <= seen_reg | {b_edge, a_edge};
                last_ch_reg <= this_ch;
                chatter_reg <= (this_ch == last_ch_reg) && seen_reg[this_ch];
            end
        end
    end

    // ======================================================================
    // output sequencer
    // ======================================================================
    seq_state_e         st_reg;
    seq_state_e         st_next;
    logic [TIMER_W-1:0] cnt_reg;
    logic               dir_reg;
    logic               sel_n_reg;
    logic               pulse_reg;

    wire lead_end  = (cnt_reg == TIMER_W'(LEAD_CYCLES - 1));
    wire pulse_end = (cnt_reg == TIMER_W'(PULSE_CYCLES - 1));
    wire tail_end  = (cnt_reg == TIMER_W'(TAIL_CYCLES - 1));
    wire seq_start = (st_reg == SEQ_IDLE) && step_req;

    // next state; steps arriving while busy are dropped
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            SEQ_IDLE:  if (seq_start) st_next = SEQ_LEAD;
            SEQ_LEAD:  if (lead_end)  st_next = SEQ_PULSE;
            SEQ_PULSE: if (pulse_end) st_next = SEQ_TAIL;
            SEQ_TAIL:  if (tail_end)  st_next = SEQ_IDLE;
            default:                  st_next = SEQ_IDLE;
        endcase
    end

    wire cnt_clr = (st_next != st_reg);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg  <= SEQ_IDLE;
            cnt_reg <= '0;
        end else begin
            st_reg  <= st_next;
            cnt_reg <= cnt_clr ? '0 : cnt_reg + 1'b1;
        end
    end

    // direction set one cycle ahead of select, then held
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dir_reg <= 1'b0;
        end else if (seq_start) begin
            dir_reg <= cw_move;
        end
    end

    // select and raw pulse registered from state, a cycle behind dir
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sel_n_reg <= 1'b1;
            pulse_reg <= 1'b0;
        end else begin
            sel_n_reg <= (st_reg == SEQ_IDLE);
            pulse_reg <= (st_reg == SEQ_PULSE);
        end
    end

    // polarity applied from the synchronized pin, so a change reaches the pins three cycles later; no flop
    // here, or the clock would trail select by one cycle at the pins
    wire clk_level = pulse_reg ^ inv_sync;

    // pins released during the power-on quiet time
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            step_out <= '{sel_n: 1'b1, clk_out: 1'b0, dir_up: 1'b0};
            step_oe  <= '0;
        end else begin
            step_out <= '{sel_n: sel_n_reg, clk_out: clk_level,
                          dir_up: dir_reg};
            step_oe  <= {3{ready_reg}};
        end
    end

endmodule : quadrature_updown_pulser
